// [verilog/t4s_status.sv]
// What this block does
// - Set bit 6 on any T4 lock change.
// - Set bit 4 when T4 lacks inputs.
// - Set bit 3 on input 2 violation.
// - Flags latch; write one clears, zero ignored.
// - Status byte is bits 23..16, reset 0x50.
// - Readback bits 2..0; select zero gives monitor.
// - Set bit 2 on input 2 loss.
// - Set bit 1 on input 1 violation.
// - Set bit 0 on input 1 loss.
`timescale 1ns/1ps
module t4s_status
   import t4s_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire t4s_bus_t              bus,
   input  wire t4s_evt_t              evt,
   input  wire logic [T4S_FREQ_W-1:0] mon_freq,
   input  wire logic [T4S_FREQ_W-1:0] t4_freq,
   output logic      [7:0]            rd_data
);

   // ********************************************************************
   // Declarations.
   // ********************************************************************
   logic [7:0] stat_reg;       // Latched status flags.
   logic [7:0] stat_next;      // Next value of the status flags.
   logic [7:0] set_vec;        // Per-bit set requests this cycle.
   logic [7:0] clr_vec;        // Per-bit clear requests from software.
   logic       lock_prev_reg;  // Lock level seen last cycle.
   logic       lock_prev_next; // Next lock level sample.
   logic [7:0] ctrl_reg;       // Control byte at the select address.
   logic [7:0] ctrl_next;      // Next control byte.
   logic [7:0] rd_data_reg;    // Registered read answer.
   logic [7:0] rd_data_next;   // Next read answer.

   // ********************************************************************
   // Event sources.
   // ********************************************************************
   // The lock edge is taken against a sample that resets to unlocked, so a
   // loop already in lock at release reports one change; the reset value
   // has that flag set anyway, so nothing new is lost or invented.
   always_comb
   begin
      lock_prev_next               = evt.t4_locked;
      set_vec                      = T4S_ZERO8;
      set_vec[T4S_BIT_LOCK]        = evt.t4_locked ^ lock_prev_reg;
      set_vec[T4S_BIT_NOIN]        = evt.t4_no_input;
      set_vec[T4S_BIT_IN2V]        = evt.in2_viol;
      set_vec[T4S_BIT_IN2L]        = evt.in2_los;
      set_vec[T4S_BIT_IN1V]        = evt.in1_viol;
      set_vec[T4S_BIT_IN1L]        = evt.in1_los;
      // Only a write of one to the status address clears a bit.
      if (bus.wr && (bus.addr == T4S_ADDR_STAT))
      begin
         clr_vec = bus.wdata;
      end
      else
      begin
         clr_vec = T4S_ZERO8;
      end
   end

   // ********************************************************************
   // Status flags, one per bit.
   // ********************************************************************
   // A set in the same cycle as its clear wins, so no event is dropped.
   // Bits 7 and 5 do not exist and stay at zero.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_flag
         always_comb
         begin
            stat_next[gi] = T4S_STAT_IMPL[gi] &
                            (set_vec[gi] | (stat_reg[gi] & ~clr_vec[gi]));
         end
      end
   endgenerate

   // ********************************************************************
   // Control byte and read answer.
   // ********************************************************************
   // The answer is taken from the state before this cycle's update, so a
   // read and a clear in one cycle show the flags that were cleared.
   always_comb
   begin
      ctrl_next    = ctrl_reg;
      rd_data_next = rd_data_reg;
      if (bus.wr && (bus.addr == T4S_ADDR_CTRL))
      begin
         ctrl_next = bus.wdata;
      end
      if (bus.rd)
      begin
         if (bus.addr == T4S_ADDR_FREQ)
         begin
            if (ctrl_reg[T4S_CTRL_SEL])
            begin
               rd_data_next = {T4S_FREQ_PAD, t4_freq};
            end
            else
            begin
               rd_data_next = {T4S_FREQ_PAD, mon_freq};
            end
         end
         else if (bus.addr == T4S_ADDR_STAT)
         begin
            rd_data_next = stat_reg;
         end
         else if (bus.addr == T4S_ADDR_CTRL)
         begin
            rd_data_next = ctrl_reg;
         end
         else
         begin
            // Unmapped addresses answer zero.
            rd_data_next = T4S_ZERO8;
         end
      end
   end

   // ********************************************************************
   // State registers.
   // ********************************************************************
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         stat_reg      <= T4S_STAT_RESET;
         lock_prev_reg <= 1'b0;
         ctrl_reg      <= T4S_CTRL_RESET;
         rd_data_reg   <= T4S_ZERO8;
      end
      else
      begin
         stat_reg      <= stat_next;
         lock_prev_reg <= lock_prev_next;
         ctrl_reg      <= ctrl_next;
         rd_data_reg   <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;

   // ********************************************************************
   // Checks.
   // ********************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_stat_read;
      bus.rd && (bus.addr == T4S_ADDR_STAT);
   endsequence

   sequence s_stat_clear_all;
      bus.wr && (bus.addr == T4S_ADDR_STAT) && (bus.wdata == 8'hFF) && !(|set_vec);
   endsequence

   a_lock_change_flag: assert property ($changed(evt.t4_locked) |=> stat_reg[T4S_BIT_LOCK])
      else $error("lock change not flagged");
   a_no_input_flag: assert property (evt.t4_no_input |=> stat_reg[T4S_BIT_NOIN])
      else $error("no valid input not flagged");
   a_in2_viol_flag: assert property (evt.in2_viol |=> stat_reg[T4S_BIT_IN2V])
      else $error("input 2 violation not flagged");
   a_flag_holds: assert property (!(bus.wr && (bus.addr == T4S_ADDR_STAT)) |=>
                                 ((stat_reg & $past(stat_reg)) == $past(stat_reg)))
      else $error("flag dropped without a clear");
   a_clear_all: assert property (s_stat_clear_all |=> (stat_reg == T4S_ZERO8))
      else $error("write of ones did not clear flags");
   a_unused_zero: assert property ((stat_reg & ~T4S_STAT_IMPL) == T4S_ZERO8)
      else $error("unused status bit set");
   a_stat_readback: assert property (s_stat_read |=> (rd_data == $past(stat_reg)))
      else $error("status read returned wrong value");
   a_freq_monitor: assert property ((bus.rd && (bus.addr == T4S_ADDR_FREQ) && !ctrl_reg[T4S_CTRL_SEL])
                                    |=> (rd_data == {T4S_FREQ_PAD, $past(mon_freq)}))
      else $error("monitor frequency readback wrong");
   a_freq_t4: assert property ((bus.rd && (bus.addr == T4S_ADDR_FREQ) && ctrl_reg[T4S_CTRL_SEL])
                               |=> (rd_data == {T4S_FREQ_PAD, $past(t4_freq)}))
      else $error("T4 frequency readback wrong");
   a_in2_los_flag: assert property (evt.in2_los |=> stat_reg[T4S_BIT_IN2L])
      else $error("input 2 loss not flagged");
   a_in1_viol_flag: assert property (evt.in1_viol |=> stat_reg[T4S_BIT_IN1V])
      else $error("input 1 violation not flagged");
   a_in1_los_flag: assert property (evt.in1_los |=> stat_reg[T4S_BIT_IN1L])
      else $error("input 1 loss not flagged");

   // ********************************************************************
   // Checks on clearing and on the readback select.
   // ********************************************************************
   // A status write is the only way software touches the flags; these
   // sequences name its forms so that the properties below read plainly.
   sequence s_stat_write;
      bus.wr && (bus.addr == T4S_ADDR_STAT);
   endsequence

   sequence s_stat_write_zero;
      bus.wr && (bus.addr == T4S_ADDR_STAT) && (bus.wdata == T4S_ZERO8);
   endsequence

   // Outside reset, the select bit only moves on a write to the control byte.
   sequence s_select_t4;
      bus.wr && (bus.addr == T4S_ADDR_CTRL) && bus.wdata[T4S_CTRL_SEL];
   endsequence

   sequence s_select_mon;
      bus.wr && (bus.addr == T4S_ADDR_CTRL) && !bus.wdata[T4S_CTRL_SEL];
   endsequence

   // An event in the same cycle as a clear must survive it, or an error
   // that arrives while software is tidying up would go unseen.
   a_set_wins: assert property (s_stat_write |=>
                                ((~stat_reg & $past(set_vec) & T4S_STAT_IMPL) == T4S_ZERO8))
      else $error("event lost to a same-cycle clear");
   // A status write of all zeros must leave every flag alone.
   a_zero_write_keeps: assert property (s_stat_write_zero |=>
                                        ((stat_reg & $past(stat_reg)) == $past(stat_reg)))
      else $error("write of zero cleared a flag");
   a_select_t4: assert property (s_select_t4 |=> ctrl_reg[T4S_CTRL_SEL])
      else $error("select of T4 readback not taken");
   a_select_mon: assert property (s_select_mon |=> !ctrl_reg[T4S_CTRL_SEL])
      else $error("select of monitor readback not taken");
   // The upper readback bits carry nothing and must read as zero.
   a_freq_pad_zero: assert property ((bus.rd && (bus.addr == T4S_ADDR_FREQ)) |=>
                                     (rd_data[7:T4S_FREQ_W] == T4S_FREQ_PAD))
      else $error("unused readback bits not zero");

endmodule

// [pkg/t4s_pkg.sv]
// ********************************************************************
// Constants and carriers for the Lock_change_flag and frequency readback.
// ********************************************************************
package t4s_pkg;

   // Register addresses on the device's byte-wide register port.
   localparam logic [7:0] T4S_ADDR_FREQ = 8'h07;  // Frequency readback, top bits.
   localparam logic [7:0] T4S_ADDR_STAT = 8'h08;  // Interrupt status bits 23..16.
   localparam logic [7:0] T4S_ADDR_CTRL = 8'h4B;  // Control byte holding the readback select.

   // Field positions inside the status byte.
   localparam int T4S_BIT_LOCK = 6;  // Lock change of the T4 loop.
   localparam int T4S_BIT_NOIN = 4;  // No valid input for the T4 loop.
   localparam int T4S_BIT_IN2V = 3;  // Input 2 code violation.
   localparam int T4S_BIT_IN2L = 2;  // Input 2 signal loss.
   localparam int T4S_BIT_IN1V = 1;  // Input 1 code violation.
   localparam int T4S_BIT_IN1L = 0;  // Input 1 signal loss.

   // Readback select bit in the control byte.
   localparam int T4S_CTRL_SEL = 4;

   // Reset values and masks.
   localparam logic [7:0] T4S_STAT_RESET = 8'h50;  // Bits 6 and 4 set.
   localparam logic [7:0] T4S_STAT_IMPL  = 8'h5F;  // Bits 7 and 5 do not exist.
   localparam logic [7:0] T4S_CTRL_RESET = 8'h00;  // Monitor loop selected.
   localparam logic [7:0] T4S_ZERO8      = 8'h00;  // Idle value of a byte.
   localparam int         T4S_FREQ_W     = 3;      // Frequency bits 18..16.
   localparam logic [4:0] T4S_FREQ_PAD   = 5'h00;  // Unused readback bits 7..3.

   // Event and level sources from the device's own logic.
   typedef struct packed
   {
      logic t4_locked;    // Level: T4 loop is in lock.
      logic t4_no_input;  // Level: no valid reference for the T4 loop.
      logic in2_viol;     // Code violation seen on input 2.
      logic in2_los;      // Signal loss seen on input 2.
      logic in1_viol;     // Code violation seen on input 1.
      logic in1_los;      // Signal loss seen on input 1.
   } t4s_evt_t;

   // Register port request.
   typedef struct packed
   {
      logic       wr;     // Write strobe, one cycle.
      logic       rd;     // Read strobe, one cycle.
      logic [7:0] addr;   // Register address.
      logic [7:0] wdata;  // Write data.
   } t4s_bus_t;

endpackage

// [verilog/t4s_status_unused_placeholder_removed.sv]
`timescale 1ns/1ps

// [testbench/t4s_status_tb_top.sv]
`timescale 1ns/1ps
module t4s_status_tb_top;
   import t4s_pkg::*;

   // ************************************************************
   // Signals and counters.
   // ************************************************************
   logic                  core_clk;     // Bench clock, 20 ns period.
   logic                  rst;          // Asynchronous reset, active high.
   t4s_bus_t              bus;          // Register port request.
   t4s_evt_t              evt;          // Event and level sources.
   logic [T4S_FREQ_W-1:0] mon_freq;     // Monitor loop frequency bits.
   logic [T4S_FREQ_W-1:0] t4_freq;      // T4 loop frequency bits.
   logic [7:0]            rd_data;      // Read answer from the block.
   int                    n_fail;       // Mismatches seen so far.
   int                    comparisons;  // Comparisons made so far.

   t4s_status u_dut (.core_clk(core_clk), .rst(rst), .bus(bus), .evt(evt),
                     .mon_freq(mon_freq), .t4_freq(t4_freq), .rd_data(rd_data));

   // The clock toggles every half period for the whole run.
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ************************************************************
   // Access and compare tasks.
   // ************************************************************
   // Compares one byte; case inequality so an unknown never matches.
   task automatic chk(input logic [7:0] exp, input logic [7:0] act);
      comparisons++;
      if (act !== exp)
      begin
         n_fail++;
         $display("MISMATCH at %0t: expected %h, got %h", $time, exp, act);
      end
   endtask

   // One write strobe, held across exactly one sampling edge.
   task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge core_clk);
      bus.wr <= 1'b1;
      bus.addr <= addr;
      bus.wdata <= data;
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask

   // One read strobe; the answer is settled by the following falling edge.
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge core_clk);
      bus.rd <= 1'b1;
      bus.addr <= addr;
      @(posedge core_clk);
      bus.rd <= 1'b0;
      @(negedge core_clk);
      chk(exp, rd_data);
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ************************************************************
   // Watchdog.
   // ************************************************************
   // The tests need under two hundred cycles; ten thousand means a hang.
   initial
   begin
      #200000;
      n_fail++;
      complete_run();
   end

   // ************************************************************
   // Test sequence.
   // ************************************************************
   initial
   begin
      rst = 1'b1;
      bus = '0;
      evt = '0;
      mon_freq = 3'h5;
      t4_freq = 3'h2;
      n_fail = 0;
      comparisons = 0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rd_chk(T4S_ADDR_STAT, T4S_STAT_RESET);
      rd_chk(T4S_ADDR_CTRL, 8'h00);
      wr_reg(T4S_ADDR_STAT, 8'h00);
      rd_chk(T4S_ADDR_STAT, 8'h50);
      wr_reg(T4S_ADDR_STAT, 8'hFF);
      rd_chk(T4S_ADDR_STAT, 8'h00);
      // Each one-cycle event must latch its own bit only, bits 4 down to 0.
      for (int i = 0; i < 5; i++)
      begin
         @(posedge core_clk);
         evt <= t4s_evt_t'(6'h01 << i);
         @(posedge core_clk);
         evt <= '0;
         rd_chk(T4S_ADDR_STAT, 8'h01 << i);
         wr_reg(T4S_ADDR_STAT, 8'h01 << i);
         rd_chk(T4S_ADDR_STAT, 8'h00);
      end
      // Gaining lock and then losing it each set the lock flag.
      @(posedge core_clk);
      evt.t4_locked <= 1'b1;
      rd_chk(T4S_ADDR_STAT, 8'h40);
      wr_reg(T4S_ADDR_STAT, 8'hFF);
      rd_chk(T4S_ADDR_STAT, 8'h00);
      @(posedge core_clk);
      evt.t4_locked <= 1'b0;
      rd_chk(T4S_ADDR_STAT, 8'h40);
      wr_reg(T4S_ADDR_STAT, 8'h40);
      // A persisting no-input level sets the flag again after a clear.
      @(posedge core_clk);
      evt.t4_no_input <= 1'b1;
      wr_reg(T4S_ADDR_STAT, 8'h10);
      rd_chk(T4S_ADDR_STAT, 8'h10);
      @(posedge core_clk);
      evt.t4_no_input <= 1'b0;
      wr_reg(T4S_ADDR_STAT, 8'h10);
      rd_chk(T4S_ADDR_STAT, 8'h00);
      // Readback follows the select bit; writes to it are ignored.
      rd_chk(T4S_ADDR_FREQ, {T4S_FREQ_PAD, 3'h5});
      wr_reg(T4S_ADDR_CTRL, 8'h10);
      rd_chk(T4S_ADDR_FREQ, {T4S_FREQ_PAD, 3'h2});
      wr_reg(T4S_ADDR_FREQ, 8'hFF);
      rd_chk(T4S_ADDR_FREQ, {T4S_FREQ_PAD, 3'h2});
      wr_reg(T4S_ADDR_CTRL, 8'h00);
      rd_chk(T4S_ADDR_FREQ, {T4S_FREQ_PAD, 3'h5});
      rd_chk(8'h33, 8'h00);
      // A reset in mid-run restores the status byte and the select bit.
      wr_reg(T4S_ADDR_CTRL, 8'h10);
      wr_reg(T4S_ADDR_STAT, 8'hFF);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rd_chk(T4S_ADDR_STAT, T4S_STAT_RESET);
      rd_chk(T4S_ADDR_FREQ, {T4S_FREQ_PAD, 3'h5});
      complete_run();
   end

endmodule
